/* File: src/hbd_pkg.sv */
// Function
// - Host port pin functions follow bus type strapped at reset release.
// - Indirect bus types use address bit one as command/data selector.
// - Single-select mode: chip select alone qualifies an access in progress.
// - Single-select mode: space select high reaches buffer, low reaches registers.
// - Single-select access with space select low goes to register space.
// - Dual-select mode: primary chip select is active-low buffer select only.
// - Dual-select mode: space select is active-low register select; buffer select wins when both are low.
// - Bus types one and two: read strobe is an active-low read enable.
// - Bus type one: upper lane input enables data bits fifteen to eight.
package hbd_pkg;
    // Strap field positions within boot_strap
    localparam int STRAP_W        = 3;
    localparam int STRAP_IND_BIT  = 2;
    localparam int STRAP_TYPE_MSB = 1;
    localparam int STRAP_TYPE_LSB = 0;
    // Bus type codes in the low strap bits
    localparam logic [1:0] BT_68     = 2'h0;
    localparam logic [1:0] BT_80_T1  = 2'h1;
    localparam logic [1:0] BT_80_T2  = 2'h2;
    localparam logic [1:0] BT_80_T3  = 2'h3;
    localparam logic [2:0] STRAP_RST = 3'h1;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam logic [15:0] DATA_RST = 16'h0000;

    typedef enum logic [1:0] {HBD_IDLE, HBD_BUF, HBD_REG} hbd_space_t;
endpackage : hbd_pkg

/* File: src/hbd_dec_if.sv */
`timescale 1ns/1ps
// Decoded access qualifiers passed from the decoder to the port top
interface hbd_dec_if;
    logic buf_sel;
    logic reg_sel;
    logic rd_en;
    logic wr_en;
    logic hi_en;
    logic lo_en;
    logic cmd;
    modport dec (output buf_sel, reg_sel, rd_en, wr_en, hi_en, lo_en, cmd);
    modport top (input  buf_sel, reg_sel, rd_en, wr_en, hi_en, lo_en, cmd);
endinterface : hbd_dec_if

/* File: src/hbd_decode.sv */
`timescale 1ns/1ps
// Combinational pin-function decoder for the strapped bus type
module hbd_decode
    import hbd_pkg::*;
(
    input  wire logic [STRAP_W-1:0] strap,
    input  wire logic               dual_cs,
    input  wire logic               chip_sel_n,
    input  wire logic               space_sel,
    input  wire logic               addr1,
    input  wire logic               rd_pin_n,
    input  wire logic               wr_pin_n,
    input  wire logic               be1_n,
    input  wire logic               be0_n,
    hbd_dec_if.dec                  d
);
    logic [1:0] btype;
    logic       any_sel;
    assign btype = strap[STRAP_TYPE_MSB:STRAP_TYPE_LSB];

    // Space selection and qualified strobes
    always_comb begin
        if (dual_cs) begin
            d.buf_sel = !chip_sel_n;
            d.reg_sel = !space_sel;
        end else begin
            d.buf_sel = !chip_sel_n && space_sel;
            d.reg_sel = !chip_sel_n && !space_sel;
        end
        any_sel = d.buf_sel || d.reg_sel;
        d.cmd   = strap[STRAP_IND_BIT] && addr1;
        d.rd_en = 1'b0;
        d.wr_en = 1'b0;
        d.hi_en = 1'b0;
        d.lo_en = 1'b0;
        if (any_sel) begin
            case (btype)
                BT_68: begin
                    d.rd_en = wr_pin_n && !(be1_n && be0_n);
                    d.wr_en = !wr_pin_n && !(be1_n && be0_n);
                    d.hi_en = !be1_n;
                    d.lo_en = !be0_n;
                end
                BT_80_T1: begin
                    d.rd_en = !rd_pin_n;
                    d.wr_en = !wr_pin_n;
                    d.hi_en = !be1_n;
                    d.lo_en = !be0_n;
                end
                BT_80_T2: begin
                    d.rd_en = !rd_pin_n;
                    d.wr_en = !be1_n || !be0_n;
                    d.hi_en = !rd_pin_n || !be1_n;
                    d.lo_en = !rd_pin_n || !be0_n;
                end
                default: begin
                    d.rd_en = !rd_pin_n || !be1_n;
                    d.wr_en = !wr_pin_n || !be0_n;
                    d.hi_en = !be1_n || !be0_n;
                    d.lo_en = !rd_pin_n || !wr_pin_n;
                end
            endcase
        end
    end
endmodule : hbd_decode

/* File: src/hbd_top.sv */
`timescale 1ns/1ps
// Host port front end: strap capture, space steering and data drive
module hbd_top
    import hbd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [STRAP_W-1:0] boot_strap,
    input  wire logic              dual_cs_mode,
    input  wire logic [ADDR_W:1]   host_addr,
    input  wire logic              chip_sel_n,
    input  wire logic              space_sel,
    input  wire logic              read_n,
    input  wire logic              write_n,
    input  wire logic              upper_lane_enable_n,
    input  wire logic              lower_lane_enable_n,
    input  wire logic [DATA_W-1:0] host_bus_word_in,
    output logic      [DATA_W-1:0] host_bus_word_out,
    output logic      [DATA_W-1:0] host_bus_word_oe,
    input  wire logic [DATA_W-1:0] rd_data,
    output logic                   buf_access,
    output logic                   reg_access,
    output logic                   acc_read,
    output logic                   acc_write,
    output logic                   acc_cmd,
    output logic      [ADDR_W:1]   acc_addr,
    output logic      [1:0]        acc_lanes,
    output logic      [DATA_W-1:0] acc_wdata,
    output logic      [STRAP_W-1:0] bus_type
);
    hbd_dec_if  dif ();
    logic [STRAP_W-1:0] strap;
    logic               strap_taken;
    logic [STRAP_W-1:0] next_strap;
    logic               next_strap_taken;
    hbd_space_t         space;
    hbd_space_t         next_space;
    logic [DATA_W-1:0]  next_out;
    logic [DATA_W-1:0]  next_oe;
    logic               next_buf_access;
    logic               next_reg_access;
    logic               next_acc_read;
    logic               next_acc_write;
    logic               next_acc_cmd;
    logic [ADDR_W:1]    next_acc_addr;
    logic [1:0]         next_acc_lanes;
    logic [DATA_W-1:0]  next_acc_wdata;
    logic [STRAP_W-1:0] next_bus_type;

    hbd_decode u_dec (
        .strap      (strap),
        .dual_cs    (dual_cs_mode),
        .chip_sel_n (chip_sel_n),
        .space_sel  (space_sel),
        .addr1      (host_addr[1]),
        .rd_pin_n   (read_n),
        .wr_pin_n   (write_n),
        .be1_n      (upper_lane_enable_n),
        .be0_n      (lower_lane_enable_n),
        .d          (dif)
    );

    // Strap capture in the first cycle after reset release
    always_comb begin
        next_strap       = strap;
        next_strap_taken = strap_taken;
        if (!strap_taken) begin
            next_strap       = boot_strap;
            next_strap_taken = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            strap       <= STRAP_RST;
            strap_taken <= 1'b0;
        end else begin
            strap       <= next_strap;
            strap_taken <= next_strap_taken;
        end
    end

    // Space steering, access qualifiers and data drive per lane
    always_comb begin
        next_space = HBD_IDLE;
        if (strap_taken && dif.buf_sel) begin
            next_space = HBD_BUF;
        end else if (strap_taken && dif.reg_sel) begin
            next_space = HBD_REG;
        end
        // Read data and lane enables only while reading a selected space
        next_out = DATA_RST;
        next_oe  = DATA_RST;
        if (next_space != HBD_IDLE && dif.rd_en) begin
            next_out = rd_data;
            next_oe  = {{8{dif.hi_en}}, {8{dif.lo_en}}};
        end
        // Access strobes pass only while a space is selected
        next_buf_access = (next_space == HBD_BUF);
        next_reg_access = (next_space == HBD_REG);
        next_acc_read   = (next_space != HBD_IDLE) && dif.rd_en;
        next_acc_write  = (next_space != HBD_IDLE) && dif.wr_en;
        next_acc_cmd    = dif.cmd;
        // Indirect buses carry no address, so the forwarded address reads zero
        next_acc_addr   = host_addr;
        if (strap[STRAP_IND_BIT]) begin
            next_acc_addr = '0;
        end
        next_acc_lanes  = {dif.hi_en, dif.lo_en};
        next_acc_wdata  = host_bus_word_in;
        next_bus_type   = strap;
    end

    // Output registers, all cleared in reset except bus_type, which loads STRAP_RST
    always_ff @(posedge clk) begin
        if (rst) begin
            space             <= HBD_IDLE;
            host_bus_word_out <= DATA_RST;
            host_bus_word_oe  <= DATA_RST;
            buf_access        <= 1'b0;
            reg_access        <= 1'b0;
            acc_read          <= 1'b0;
            acc_write         <= 1'b0;
            acc_cmd           <= 1'b0;
            acc_addr          <= '0;
            acc_lanes         <= 2'h0;
            acc_wdata         <= DATA_RST;
            bus_type          <= STRAP_RST;
        end else begin
            space             <= next_space;
            host_bus_word_out <= next_out;
            host_bus_word_oe  <= next_oe;
            buf_access        <= next_buf_access;
            reg_access        <= next_reg_access;
            acc_read          <= next_acc_read;
            acc_write         <= next_acc_write;
            acc_cmd           <= next_acc_cmd;
            acc_addr          <= next_acc_addr;
            acc_lanes         <= next_acc_lanes;
            acc_wdata         <= next_acc_wdata;
            bus_type          <= next_bus_type;
        end
    end

    // Space selection checks
    a_idle_no_drive: assert property (@(posedge clk) disable iff (rst)
        !(buf_access || reg_access) |-> host_bus_word_oe == '0)
        else $error("data driven while unselected");
    a_idle_no_strobe: assert property (@(posedge clk) disable iff (rst)
        !(buf_access || reg_access) |-> !acc_read && !acc_write)
        else $error("strobe passed while unselected");
    a_single_buf: assert property (@(posedge clk) disable iff (rst)
        strap_taken && !dual_cs_mode && !chip_sel_n && space_sel
        |=> buf_access && !reg_access)
        else $error("single mode buffer route wrong");
    a_single_reg: assert property (@(posedge clk) disable iff (rst)
        strap_taken && !dual_cs_mode && !chip_sel_n && !space_sel
        |=> reg_access && !buf_access)
        else $error("single mode register route wrong");
    a_single_cs: assert property (@(posedge clk) disable iff (rst)
        !dual_cs_mode && chip_sel_n |=> !buf_access && !reg_access)
        else $error("access without chip select");
    a_dual_buf: assert property (@(posedge clk) disable iff (rst)
        strap_taken && dual_cs_mode && !chip_sel_n |=> buf_access)
        else $error("dual mode buffer select ignored");
    a_dual_reg: assert property (@(posedge clk) disable iff (rst)
        strap_taken && dual_cs_mode && chip_sel_n && !space_sel
        |=> reg_access)
        else $error("dual mode register select ignored");
    a_dual_both: assert property (@(posedge clk) disable iff (rst)
        strap_taken && dual_cs_mode && !chip_sel_n && !space_sel
        |=> buf_access && !reg_access)
        else $error("dual mode double select not steered to buffer");
    a_dual_none: assert property (@(posedge clk) disable iff (rst)
        dual_cs_mode && chip_sel_n && space_sel |=> !buf_access && !reg_access)
        else $error("dual mode access without any select");
    a_space_flags: assert property (@(posedge clk) disable iff (rst)
        buf_access == (space == HBD_BUF) && reg_access == (space == HBD_REG))
        else $error("space flags disagree with space state");

    // Strobe and lane checks
    a_read_t1: assert property (@(posedge clk) disable iff (rst)
        strap_taken && strap[1:0] == BT_80_T1 && !dual_cs_mode
        && !chip_sel_n && !read_n |=> acc_read)
        else $error("read strobe not taken");
    a_read_t2: assert property (@(posedge clk) disable iff (rst)
        strap_taken && strap[STRAP_TYPE_MSB:STRAP_TYPE_LSB] == BT_80_T2 && !dual_cs_mode
        && !chip_sel_n && !read_n |=> acc_read)
        else $error("type two read strobe not taken");
    a_upper_t1: assert property (@(posedge clk) disable iff (rst)
        strap_taken && strap[1:0] == BT_80_T1 && !dual_cs_mode
        && !chip_sel_n && !read_n && upper_lane_enable_n
        |=> host_bus_word_oe[15:8] == 8'h00)
        else $error("upper lane driven while disabled");
    a_lane_pair: assert property (@(posedge clk) disable iff (rst)
        acc_read |-> host_bus_word_oe == {{8{acc_lanes[1]}}, {8{acc_lanes[0]}}})
        else $error("drive enables disagree with lanes");

    // Strap and command checks
    a_cmd_indirect: assert property (@(posedge clk) disable iff (rst)
        strap_taken && !strap[STRAP_IND_BIT] |=> !acc_cmd)
        else $error("command flag in direct mode");
    a_cmd_addr1: assert property (@(posedge clk) disable iff (rst)
        strap_taken && strap[STRAP_IND_BIT] |=> acc_cmd == $past(host_addr[1]))
        else $error("command flag does not follow address bit one");
    a_addr_indirect: assert property (@(posedge clk) disable iff (rst)
        strap_taken && strap[STRAP_IND_BIT] |=> acc_addr == '0)
        else $error("address forwarded in indirect mode");
    a_strap_hold: assert property (@(posedge clk) disable iff (rst)
        strap_taken |=> $stable(strap))
        else $error("strap changed after capture");
    a_bus_type: assert property (@(posedge clk) disable iff (rst)
        strap_taken |=> bus_type == $past(strap))
        else $error("bus type does not show captured strap");

    // Scenario covers
    c_buf_read: cover property (@(posedge clk) buf_access && acc_read);
    c_reg_write: cover property (@(posedge clk) reg_access && acc_write);
    c_cmd: cover property (@(posedge clk) acc_cmd && acc_write);
    c_dual_reg: cover property (@(posedge clk) dual_cs_mode && reg_access && acc_read);
    c_upper_off: cover property (@(posedge clk) acc_read && acc_lanes == 2'h1);
endmodule : hbd_top

/* File: verification/hbd_host_model.sv */
`timescale 1ns/1ps
// Host CPU side of the port: drives every pin and holds it until the next call
module hbd_host_model
    import hbd_pkg::*;
(
    output logic              chip_sel_n,
    output logic              space_sel,
    output logic              read_n,
    output logic              write_n,
    output logic [1:0]        lanes_n,
    output logic [ADDR_W:1]   addr,
    output logic [DATA_W-1:0] wdata
);
    // Space select high for the buffer, low for registers in single-select mode; in dual-select mode low selects registers
    task automatic set_pins(input logic cs_n, input logic ss, input logic rd_n,
                            input logic wr_n, input logic [1:0] ln_n,
                            input logic [ADDR_W:1] a, input logic [DATA_W-1:0] d);
        chip_sel_n = cs_n;
        space_sel  = ss;
        read_n     = rd_n;
        write_n    = wr_n;
        lanes_n    = ln_n;
        addr       = a;
        wdata      = d;
    endtask : set_pins

    // Idle bus at time zero: nothing selected, strobes high
    initial begin
        set_pins(1'b1, 1'b0, 1'b1, 1'b1, 2'b11, '0, 16'hffff);
    end
endmodule : hbd_host_model

/* File: verification/tb_host_bus_space_decode.sv */
`timescale 1ns/1ps
// Self-checking bench for the host port front end
module tb_host_bus_space_decode;
    import hbd_pkg::*;
    logic                clk;
    logic                rst;
    logic [STRAP_W-1:0]  strap;
    logic                dual;
    logic [DATA_W-1:0]   rdd;
    logic                cs_n, ss, rd_n, wr_n;
    logic [1:0]          ln_n;
    logic [ADDR_W:1]     addr, acc_addr;
    logic [DATA_W-1:0]   wdata, word_out, word_oe, acc_wdata;
    logic                buf_access, reg_access, acc_read, acc_write, acc_cmd;
    logic [1:0]          acc_lanes;
    logic [STRAP_W-1:0]  bus_type;
    int                  num_errors = 0;
    int                  total_checks = 0;
    int                  cycles = 0;

    hbd_host_model u_host (.chip_sel_n(cs_n), .space_sel(ss), .read_n(rd_n), .write_n(wr_n),
                           .lanes_n(ln_n), .addr(addr), .wdata(wdata));
    hbd_top DUT (.clk(clk), .rst(rst), .boot_strap(strap), .dual_cs_mode(dual),
                 .host_addr(addr), .chip_sel_n(cs_n), .space_sel(ss), .read_n(rd_n),
                 .write_n(wr_n), .upper_lane_enable_n(ln_n[1]),
                 .lower_lane_enable_n(ln_n[0]), .host_bus_word_in(wdata),
                 .host_bus_word_out(word_out), .host_bus_word_oe(word_oe), .rd_data(rdd),
                 .buf_access(buf_access), .reg_access(reg_access), .acc_read(acc_read),
                 .acc_write(acc_write), .acc_cmd(acc_cmd), .acc_addr(acc_addr),
                 .acc_lanes(acc_lanes), .acc_wdata(acc_wdata), .bus_type(bus_type));

    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Cycle ceiling against a hung run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected word at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check_word

    // Flags in order: buffer, register, read, write, command
    task automatic check_flags(input logic [4:0] exp);
        total_checks++;
        if ({buf_access, reg_access, acc_read, acc_write, acc_cmd} !== exp) begin
            num_errors++;
            $display("unexpected flags at %0t: want %b", $time, exp);
        end
    endtask : check_flags

    // Reset for six cycles with the given strap, then let the strap be captured
    task automatic do_reset(input logic [2:0] s, input logic d);
        strap = s;
        dual = d;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        // Strap is taken at the first edge and shown on bus_type at the second
        repeat (2) @(posedge clk);
        #1;
        check_word({13'h0000, bus_type}, {13'h0000, s});
    endtask : do_reset

    // One host cycle: pins set after an edge, outputs judged after the next
    task automatic step(input logic c, input logic s, input logic r, input logic w,
                        input logic [1:0] l, input logic [ADDR_W:1] a);
        u_host.set_pins(c, s, r, w, l, a, 16'h5a0f);
        @(posedge clk);
        #1;
    endtask : step

    task automatic test_single();
        do_reset(3'h1, 1'b0);
        step(1'b0, 1'b1, 1'b0, 1'b1, 2'b00, 17'h0_1234);
        check_flags(5'b10100);
        check_word(acc_addr[16:1], 16'h1234);
        check_word(word_oe, 16'hffff);
        check_word(word_out, 16'ha5c3);
        step(1'b0, 1'b0, 1'b1, 1'b0, 2'b00, 17'h0_0010);
        check_flags(5'b01010);
        check_word(acc_wdata, 16'h5a0f);
        step(1'b0, 1'b1, 1'b0, 1'b1, 2'b10, 17'h0_0020);
        check_word(word_oe, 16'h00ff);
        check_word({14'h0000, acc_lanes}, 16'h0001);
        step(1'b1, 1'b0, 1'b0, 1'b0, 2'b00, 17'h0_0020);
        check_flags(5'b00000);
        check_word(word_oe, 16'h0000);
    endtask : test_single

    task automatic test_dual();
        do_reset(3'h1, 1'b1);
        step(1'b1, 1'b0, 1'b0, 1'b1, 2'b00, 17'h0_0008);
        check_flags(5'b01100);
        step(1'b0, 1'b1, 1'b0, 1'b1, 2'b00, 17'h0_0008);
        check_flags(5'b10100);
        step(1'b0, 1'b0, 1'b0, 1'b1, 2'b00, 17'h0_0008);
        check_flags(5'b10100);
        step(1'b1, 1'b1, 1'b0, 1'b0, 2'b00, 17'h0_0008);
        check_flags(5'b00000);
    endtask : test_dual

    // Indirect bus: space select tied low, address bit one picks command or data
    task automatic test_indirect();
        do_reset(3'h5, 1'b0);
        step(1'b0, 1'b0, 1'b0, 1'b1, 2'b00, 17'h0_0001);
        check_flags(5'b01101);
        check_word(acc_addr[16:1], 16'h0000);
        step(1'b0, 1'b0, 1'b0, 1'b1, 2'b00, 17'h0_0000);
        check_flags(5'b01100);
        step(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 17'h0_0001);
        check_flags(5'h0b);
    endtask : test_indirect

    // Bus type 68: read/write level with two data strobes
    task automatic test_type68();
        do_reset(3'h0, 1'b0);
        step(1'b0, 1'b0, 1'b1, 1'b1, 2'h0, 17'h0_0004);
        check_flags(5'h0c);
        check_word(word_oe, 16'hffff);
        step(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 17'h0_0004);
        check_flags(5'h0a);
        step(1'b0, 1'b0, 1'b1, 1'b1, 2'h3, 17'h0_0004);
        check_flags(5'h08);
    endtask : test_type68

    // Bus type two: read strobe plus per-lane write strobes
    task automatic test_type2();
        do_reset(3'h2, 1'b0);
        step(1'b0, 1'b1, 1'b0, 1'b1, 2'h3, 17'h0_0040);
        check_flags(5'h14);
        check_word(word_oe, 16'hffff);
        step(1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 17'h0_0040);
        check_flags(5'h12);
        check_word({14'h0000, acc_lanes}, 16'h0002);
    endtask : test_type2

    // Bus type three: separate read and write strobes per lane
    task automatic test_type3();
        do_reset(3'h3, 1'b0);
        step(1'b0, 1'b1, 1'b0, 1'b1, 2'h3, 17'h0_0080);
        check_flags(5'h14);
        check_word(word_oe, 16'h00ff);
        step(1'b0, 1'b1, 1'b1, 1'b1, 2'h2, 17'h0_0080);
        check_flags(5'h12);
        check_word({14'h0000, acc_lanes}, 16'h0002);
    endtask : test_type3

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        rst = 1'b1;
        strap = 3'h1;
        dual = 1'b0;
        rdd = 16'ha5c3;
        test_single();
        test_dual();
        test_indirect();
        test_type68();
        test_type2();
        test_type3();
        tally_and_finish();
    end
endmodule : tb_host_bus_space_decode
